// ### tcic_pkg.sv
// package: register map, field positions and encodings of the timer channel
package tcic_pkg;
    localparam logic [11:0] ADDR_RESET_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_CLOCK_EN    = 12'h004;
    localparam logic [11:0] ADDR_PRESCALER   = 12'h008;
    localparam logic [11:0] ADDR_MODE        = 12'h00C;
    localparam logic [11:0] ADDR_COMPARE     = 12'h010;
    localparam logic [11:0] ADDR_OUT_MS      = 12'h014;
    localparam logic [11:0] ADDR_OUT_POL     = 12'h018;
    localparam logic [11:0] ADDR_OUT_VALUE   = 12'h01C;
    localparam logic [11:0] ADDR_OUT_ENABLE  = 12'h020;
    localparam logic [11:0] ADDR_START       = 12'h024;
    localparam logic [11:0] ADDR_CAPTURE     = 12'h028;
    localparam logic [11:0] ADDR_STATUS      = 12'h02C;

    localparam int UNIT_BIT    = 0;
    localparam int CHAN_BIT    = 1;
    localparam int CKS_HI      = 15;
    localparam int CKS_LO      = 14;
    localparam int CCS_BIT     = 12;
    localparam int SPLIT_BIT   = 11;
    localparam int STS_HI      = 10;
    localparam int STS_LO      = 8;
    localparam int CIS_HI      = 7;
    localparam int CIS_LO      = 6;
    localparam int MD_HI       = 3;
    localparam int MD_LO       = 1;
    localparam int MD0_BIT     = 0;
    localparam int PRS0_HI     = 3;
    localparam int PRS1_LO     = 4;
    localparam int PRS2_LO     = 8;
    localparam int PRS3_LO     = 12;

    localparam logic [7:0]  RESET_CTRL_RST = 8'h01;
    localparam logic [7:0]  CLOCK_EN_RST   = 8'h00;
    localparam logic [15:0] ZERO16         = 16'h0000;
    localparam logic [15:0] CNT_ONE        = 16'h0001;
    localparam logic [7:0]  CNT8_ALL       = 8'hFF;
    localparam logic [14:0] PRE_ONE        = 15'h001;

    typedef enum logic [1:0] {
        CKS_CK0 = 2'b00,
        CKS_CK2 = 2'b01,
        CKS_CK1 = 2'b10,
        CKS_CK3 = 2'b11
    } tcic_cks_t;

    typedef enum logic [2:0] {
        TRG_SOFT    = 3'b000,
        TRG_EDGE    = 3'b001,
        TRG_BOTH    = 3'b010,
        TRG_MASTER  = 3'b100,
        TRG_MST_SLV = 3'b110
    } tcic_trig_t;

    typedef enum logic [1:0] {
        EDG_FALL  = 2'b00,
        EDG_RISE  = 2'b01,
        EDG_LOWW  = 2'b10,
        EDG_HIGHW = 2'b11
    } tcic_edge_t;

    typedef enum logic [2:0] {
        MD_INTERVAL = 3'b000,
        MD_CAPTURE  = 3'b010,
        MD_EVENT    = 3'b011,
        MD_ONECOUNT = 3'b100,
        MD_CAP_ONE  = 3'b110
    } tcic_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_COUNT = 2'b01
    } tcic_state_t;
endpackage

// ### tcic_tick_if.sv
// interface: prescaler ticks passed from the prescaler to the channel
`timescale 1ns/1ns
interface tcic_tick_if;
    logic [3:0] tick;
    modport source (output tick);
    modport sink   (input  tick);
endinterface

// ### tcic_prescaler.sv
// module: shared prescaler producing four divided tick strobes
`timescale 1ns/1ns
module tcic_prescaler
    import tcic_pkg::*;
(
    input  wire logic        clk_in,      // system clock
    input  wire logic        run_in,      // unit clocked and out of reset
    input  wire logic [15:0] prs_in,      // four 4-bit divide selectors
    tcic_tick_if.source      ticks        // one-cycle tick per divided period
);
    logic [14:0] div_q;

    function automatic logic tick_of(input logic [14:0] div, input logic [3:0] n);
        logic [15:0] mask;
        mask = (16'h0001 << n) - 16'h0001;
        tick_of = (({1'b0, div} & mask) == 16'h0000);
    endfunction

    always_ff @(posedge clk_in)
    begin
        if (!run_in)
            div_q <= '0;
        else
            div_q <= div_q + PRE_ONE;
    end

    // clock zero is fclk / 2^n, n from 0 to 15
    always_comb
    begin
        ticks.tick[0] = run_in && tick_of(div_q, prs_in[PRS0_HI:0]);
        ticks.tick[1] = run_in && tick_of(div_q, prs_in[PRS1_LO+3:PRS1_LO]);
        ticks.tick[2] = run_in && tick_of(div_q, prs_in[PRS2_LO+3:PRS2_LO]);
        ticks.tick[3] = run_in && tick_of(div_q, prs_in[PRS3_LO+3:PRS3_LO]);
    end
endmodule

// ### tcic_edge.sv
// module: input pin edge detector with start and capture edge selection
`timescale 1ns/1ns
module tcic_edge
    import tcic_pkg::*;
(
    input  wire logic       clk_in,     // system clock
    input  wire logic       ena_in,     // clock enable
    input  wire logic       rst_in,     // active-high synchronous clear
    input  wire logic       pin_in,     // channel input pin
    input  wire logic [1:0] cis_in,     // edge select field
    output logic            start_out,  // start-type valid edge
    output logic            cap_out,    // capture-type valid edge
    output logic            any_out     // either edge
);
    logic pin_q;
    logic rise;
    logic fall;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            pin_q <= 1'b0;
        else if (ena_in)
            pin_q <= pin_in;
    end

    assign rise    = ena_in && pin_in && !pin_q;
    assign fall    = ena_in && !pin_in && pin_q;
    assign any_out = rise || fall;

    always_comb
    begin
        unique case (tcic_edge_t'(cis_in))
            EDG_FALL:
            begin
                start_out = fall;
                cap_out   = fall;
            end
            EDG_RISE:
            begin
                start_out = rise;
                cap_out   = rise;
            end
            EDG_LOWW:
            begin
                start_out = fall;
                cap_out   = rise;
            end
            EDG_HIGHW:
            begin
                start_out = rise;
                cap_out   = fall;
            end
        endcase
    end
endmodule

// ### tcic_top.sv
// module: one timer channel with prescaler, mode logic, output and APB registers
`timescale 1ns/1ns

module tcic_top
    import tcic_pkg::*;
(
    input  wire logic        CLK_IN,      // 10 MHz system clock
    input  wire logic        RSTN_IN,     // synchronous reset, active low
    input  wire logic        CE_IN,       // clock enable, freezes state when low except the prescaler divider, which clears
    input  wire logic        PSEL_IN,     // apb select
    input  wire logic        PENABLE_IN,  // apb enable
    input  wire logic        PWRITE_IN,   // apb direction
    input  wire logic [11:0] PADDR_IN,    // apb byte address
    input  wire logic [31:0] PWDATA_IN,   // apb write data
    output logic      [31:0] PRDATA_OUT,  // apb read data
    output logic             PREADY_OUT,  // apb ready
    output logic             PSLVERR_OUT, // apb error on unmapped address
    input  wire logic        TIN_IN,      // channel input pin
    input  wire logic        MASTER_INT_IN, // master channel interrupt pulse
    output logic             TOUT_OUT,    // channel output pin
    output logic             INT_OUT      // channel timer interrupt pulse
);
    logic [7:0]  reset_ctrl_q;
    logic [7:0]  clock_en_q;
    logic [15:0] prescaler_q;
    logic [15:0] mode_q;
    logic [15:0] compare_q;
    logic        out_ms_q;
    logic        out_pol_q;
    logic        out_val_q;
    logic        out_en_q;
    logic [15:0] capture_q;
    logic [15:0] counter_q;
    logic [15:0] counter_d;
    logic        run_q;
    tcic_state_t state_q;
    logic        sw_start;
    logic        wr_acc;
    logic        rd_acc;
    logic        unit_rst;
    logic        unit_run;
    logic        op_tick;
    logic        cnt_tick;
    logic        edge_start;
    logic        edge_cap;
    logic        edge_any;
    logic        hw_start;
    logic        hw_cap;
    logic        start_evt;
    logic        underflow;
    logic        start_irq;
    logic        restart_ok;
    logic        fire;
    logic        toggle;
    logic        mapped;
    tcic_mode_t  mode;
    tcic_trig_t  trig;
    logic        md0;

    tcic_tick_if ticks ();

    assign unit_rst = !RSTN_IN || reset_ctrl_q[UNIT_BIT];
    assign unit_run = !unit_rst && clock_en_q[UNIT_BIT] && CE_IN;
    assign mode     = tcic_mode_t'(mode_q[MD_HI:MD_LO]);
    assign trig     = tcic_trig_t'(mode_q[STS_HI:STS_LO]);
    assign md0      = mode_q[MD0_BIT];

    tcic_prescaler u_pre (
        .clk_in (CLK_IN),
        .run_in (unit_run),
        .prs_in (prescaler_q),
        .ticks  (ticks.source)
    );

    tcic_edge u_edge (
        .clk_in    (CLK_IN),
        .ena_in    (unit_run),
        .rst_in    (unit_rst),
        .pin_in    (TIN_IN),
        .cis_in    (mode_q[CIS_HI:CIS_LO]),
        .start_out (edge_start),
        .cap_out   (edge_cap),
        .any_out   (edge_any)
    );

    function automatic logic is_capture(input tcic_mode_t m);
        is_capture = (m == MD_CAPTURE) || (m == MD_CAP_ONE);
    endfunction

    // operation clock selection
    always_comb
    begin
        unique case (tcic_cks_t'(mode_q[CKS_HI:CKS_LO]))
            CKS_CK0: op_tick = ticks.tick[0];
            CKS_CK2: op_tick = ticks.tick[2];
            CKS_CK1: op_tick = ticks.tick[1];
            CKS_CK3: op_tick = ticks.tick[3];
        endcase
    end

    // count clock source, event mode always counts pin edges
    assign cnt_tick = (mode_q[CCS_BIT] || mode == MD_EVENT) ? edge_start
                                                              : op_tick;

    // trigger sources
    always_comb
    begin
        hw_start = 1'b0;
        hw_cap   = 1'b0;
        unique case (trig)
            TRG_SOFT:
            begin
                hw_start = 1'b0;
                hw_cap   = 1'b0;
            end
            TRG_EDGE:
            begin
                hw_start = edge_start;
                hw_cap   = edge_cap;
            end
            TRG_BOTH:
            begin
                hw_start = edge_any;
                hw_cap   = edge_any;
            end
            TRG_MASTER:
            begin
                hw_start = MASTER_INT_IN;
                hw_cap   = MASTER_INT_IN;
            end
            TRG_MST_SLV:
            begin
                hw_start = MASTER_INT_IN;
                hw_cap   = edge_cap;
            end
            default:
            begin
                hw_start = 1'b0;
                hw_cap   = 1'b0;
            end
        endcase
    end

    // one-count mode honours restart only when low mode bit is set, capture one-count never does
    assign restart_ok = (mode == MD_ONECOUNT) ? md0
                      : (mode == MD_CAP_ONE)  ? 1'b0
                      : 1'b1;
    assign start_evt  = unit_run && (sw_start || (hw_start && run_q))
                        && (state_q == ST_IDLE || restart_ok);
    // start interrupt: interval/capture with low bit set, or one-count restart
    assign start_irq  = start_evt && (((mode == MD_INTERVAL || is_capture(mode))
                        && md0 && mode != MD_CAP_ONE)
                        || (mode == MD_ONECOUNT && state_q == ST_COUNT && md0));

    // 16-bit or lower-byte underflow per split bit
    assign underflow = (state_q == ST_COUNT) && cnt_tick && !is_capture(mode)
                       && (mode_q[SPLIT_BIT] ? (counter_q[7:0] == ZERO16[7:0])
                                             : (counter_q == ZERO16));
    assign fire   = start_irq || underflow
                    || (unit_run && state_q == ST_COUNT && is_capture(mode) && hw_cap);
    assign toggle = (start_irq && mode != MD_ONECOUNT) || underflow;

    // counter next value
    always_comb
    begin
        counter_d = counter_q;
        if (start_evt)
            counter_d = is_capture(mode) ? ZERO16 : compare_q;
        else if (state_q == ST_COUNT && is_capture(mode) && hw_cap)
            counter_d = ZERO16;
        else if (underflow)
            counter_d = compare_q;
        else if (state_q == ST_COUNT && cnt_tick && is_capture(mode))
            counter_d = counter_q + CNT_ONE;
        else if (state_q == ST_COUNT && cnt_tick && mode_q[SPLIT_BIT])
            counter_d = {counter_q[15:8], counter_q[7:0] - CNT_ONE[7:0]};
        else if (state_q == ST_COUNT && cnt_tick)
            counter_d = counter_q - CNT_ONE;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (unit_rst)
            counter_q <= ZERO16;
        else if (unit_run)
            counter_q <= counter_d;
    end

    // channel run state; a start wins over the stale run flag, one-count stops at underflow
    always_ff @(posedge CLK_IN)
    begin
        if (unit_rst)
            state_q <= ST_IDLE;
        else if (unit_run)
        begin
            if (start_evt)
                state_q <= ST_COUNT;
            else if (!run_q)
                state_q <= ST_IDLE;
            else if (underflow && mode == MD_ONECOUNT)
                state_q <= ST_IDLE;
        end
    end

    // capture register
    always_ff @(posedge CLK_IN)
    begin
        if (unit_rst)
            capture_q <= ZERO16;
        else if (unit_run && state_q == ST_COUNT && is_capture(mode) && hw_cap)
            capture_q <= counter_q;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (unit_rst)
            INT_OUT <= 1'b0;
        else if (CE_IN)
            INT_OUT <= fire;
    end

    // output latch: timer toggles when enabled (takes the idle flag when out_ms_q is set), software writes otherwise
    always_ff @(posedge CLK_IN)
    begin
        if (unit_rst)
            out_val_q <= 1'b0;
        else if (out_en_q && unit_run && toggle)
            out_val_q <= out_ms_q ? (state_q == ST_IDLE) : !out_val_q;
        else if (!out_en_q && wr_acc && PADDR_IN == ADDR_OUT_VALUE)
            out_val_q <= PWDATA_IN[CHAN_BIT];
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
            TOUT_OUT <= 1'b0;
        else if (CE_IN)
            TOUT_OUT <= out_val_q ^ out_pol_q;
    end

    // apb slave, zero wait states
    assign wr_acc = CE_IN && PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign rd_acc = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
    assign sw_start = wr_acc && PADDR_IN == ADDR_START && PWDATA_IN[CHAN_BIT];

    always_comb
    begin
        unique case (PADDR_IN)
            ADDR_RESET_CTRL, ADDR_CLOCK_EN, ADDR_PRESCALER, ADDR_MODE,
            ADDR_COMPARE, ADDR_OUT_MS, ADDR_OUT_POL, ADDR_OUT_VALUE,
            ADDR_OUT_ENABLE, ADDR_START, ADDR_CAPTURE, ADDR_STATUS:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    // peripheral control registers survive unit reset
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            reset_ctrl_q <= RESET_CTRL_RST;
            clock_en_q   <= CLOCK_EN_RST;
        end
        else if (wr_acc && PADDR_IN == ADDR_RESET_CTRL)
            reset_ctrl_q <= PWDATA_IN[7:0];
        else if (wr_acc && PADDR_IN == ADDR_CLOCK_EN)
            clock_en_q <= PWDATA_IN[7:0];
    end

    always_ff @(posedge CLK_IN)
    begin
        if (unit_rst)
        begin
            prescaler_q <= ZERO16;
            mode_q      <= ZERO16;
            compare_q   <= ZERO16;
            out_ms_q    <= 1'b0;
            out_pol_q   <= 1'b0;
            out_en_q    <= 1'b0;
            run_q       <= 1'b0;
        end
        else if (wr_acc)
        begin
            unique case (PADDR_IN)
                ADDR_PRESCALER:  prescaler_q <= PWDATA_IN[15:0];
                ADDR_MODE:       mode_q      <= PWDATA_IN[15:0];
                ADDR_COMPARE:    compare_q   <= PWDATA_IN[15:0];
                ADDR_OUT_MS:     out_ms_q    <= PWDATA_IN[CHAN_BIT];
                ADDR_OUT_POL:    out_pol_q   <= PWDATA_IN[CHAN_BIT];
                ADDR_OUT_ENABLE: out_en_q    <= PWDATA_IN[CHAN_BIT];
                ADDR_START:      run_q       <= run_q | PWDATA_IN[CHAN_BIT];
                ADDR_STATUS:     run_q       <= run_q & ~PWDATA_IN[CHAN_BIT];
                default:         run_q       <= run_q;
            endcase
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            PRDATA_OUT  <= '0;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end
        else if (CE_IN)
        begin
            PREADY_OUT  <= PSEL_IN && !PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !mapped;
            if (rd_acc)
            begin
                unique case (PADDR_IN)
                    ADDR_RESET_CTRL: PRDATA_OUT <= {24'h000000, reset_ctrl_q};
                    ADDR_CLOCK_EN:   PRDATA_OUT <= {24'h000000, clock_en_q};
                    ADDR_PRESCALER:  PRDATA_OUT <= {16'h0000, prescaler_q};
                    ADDR_MODE:       PRDATA_OUT <= {16'h0000, mode_q};
                    ADDR_COMPARE:    PRDATA_OUT <= {16'h0000, compare_q};
                    ADDR_OUT_MS:     PRDATA_OUT <= {30'h0000000, out_ms_q, 1'b0};
                    ADDR_OUT_POL:    PRDATA_OUT <= {30'h0000000, out_pol_q, 1'b0};
                    ADDR_OUT_VALUE:  PRDATA_OUT <= {30'h0000000, out_val_q, 1'b0};
                    ADDR_OUT_ENABLE: PRDATA_OUT <= {30'h0000000, out_en_q, 1'b0};
                    ADDR_CAPTURE:    PRDATA_OUT <= {16'h0000, capture_q};
                    ADDR_STATUS:     PRDATA_OUT <= {counter_q, 14'h000,
                                                    state_q == ST_COUNT, run_q};
                    default:         PRDATA_OUT <= '0;
                endcase
            end
        end
    end
endmodule

// ### tcic_checker.sv
// checker: bus handshake and timer output properties of the timer channel
`timescale 1ns/1ns
module tcic_checker
    import tcic_pkg::*;
(
    input wire logic        CLK_IN,      // clock
    input wire logic        RSTN_IN,     // reset
    input wire logic        CE_IN,       // enable
    input wire logic        PSEL_IN,     // select
    input wire logic        PENABLE_IN,  // enable
    input wire logic        PWRITE_IN,   // write
    input wire logic [11:0] PADDR_IN,    // address
    input wire logic [31:0] PWDATA_IN,   // wdata
    input wire logic [31:0] PRDATA_OUT,  // rdata
    input wire logic        PREADY_OUT,  // ready
    input wire logic        PSLVERR_OUT, // error
    input wire logic        TOUT_OUT,    // pin
    input wire logic        INT_OUT      // irq
);
    logic unit_rst_q;
    logic clk_en_q;
    logic wr_hit;
    logic mapped;
    assign wr_hit = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && CE_IN;
    assign mapped = PADDR_IN[1:0] == 2'h0 && PADDR_IN <= ADDR_STATUS;
    // shadow of the unit reset and clock-enable bits
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            unit_rst_q <= RESET_CTRL_RST[0];
            clk_en_q   <= CLOCK_EN_RST[0];
        end
        else if (wr_hit && PADDR_IN == ADDR_RESET_CTRL)
            unit_rst_q <= PWDATA_IN[UNIT_BIT];
        else if (wr_hit && PADDR_IN == ADDR_CLOCK_EN)
            clk_en_q <= PWDATA_IN[UNIT_BIT];
    end
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    sequence s_setup;
        PSEL_IN && !PENABLE_IN && CE_IN;
    endsequence
    sequence s_unit_held;
        unit_rst_q [*3];
    endsequence
    sequence s_clock_off;
        !clk_en_q [*3];
    endsequence
    AST_READY_AFTER_SETUP: assert property (s_setup |=> PREADY_OUT)
        else $error("ready missing after setup");
    AST_READY_IN_ACCESS: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("ready outside access phase");
    AST_READY_ONE_CYCLE: assert property (PREADY_OUT && CE_IN |=> !PREADY_OUT)
        else $error("ready held too long");
    AST_ERR_DECODE: assert property (PREADY_OUT |-> PSLVERR_OUT == !mapped)
        else $error("error flag does not match decode");
    AST_ERR_READ_ZERO: assert property (PREADY_OUT && PSLVERR_OUT && !PWRITE_IN |-> PRDATA_OUT == 32'h0)
        else $error("refused read returned data");
    AST_UNIT_HELD_QUIET: assert property (s_unit_held |-> !INT_OUT && !TOUT_OUT)
        else $error("timer active while unit held in reset");
    AST_CLOCK_OFF_NO_INT: assert property (s_clock_off |-> !INT_OUT)
        else $error("interrupt while unit clock stopped");
    AST_FREEZE: assert property (!CE_IN |=> $stable(TOUT_OUT) && $stable(INT_OUT))
        else $error("outputs moved while frozen");
    AST_RESET_QUIET: assert property (disable iff (1'b0) !RSTN_IN |=> !INT_OUT && !PREADY_OUT && !TOUT_OUT)
        else $error("outputs active after reset");
endmodule
bind tcic_top tcic_checker u_chk (.CLK_IN, .RSTN_IN, .CE_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
    .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .TOUT_OUT, .INT_OUT);

// ### tcic_pin_model.sv
// model: pulse source on the channel input pin and a watcher on the led output
`timescale 1ns/1ns
module tcic_pin_model
(
    input  wire logic clk_in,    // system clock
    input  wire logic go_in,     // request one high pulse
    input  wire logic tout_in,   // led drive from the channel
    output logic      tin_out,   // channel input pin, pulled low at rest
    output int        flips_out  // led level changes seen
);
    logic last_q = 1'b0;
    int   hold_q = 0;
    initial
    begin
        tin_out   = 1'b0;
        flips_out = 0;
    end
    always @(posedge clk_in)
    begin
        last_q <= tout_in;
        if (tout_in !== last_q)
            flips_out <= flips_out + 1;
        hold_q  <= go_in ? 3 : (hold_q > 0 ? hold_q - 1 : 0);
        tin_out <= go_in || hold_q > 1;
    end
endmodule

// ### tcic_tb.sv
// testbench: register, interval, output and capture scenarios of the timer channel
`timescale 1ns/1ns
module tb;
    import tcic_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        pena = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        perr;
    logic        tin;
    logic        tout;
    logic        irq;
    logic        go = 1'b0;
    logic [15:0] lfsr = 16'h0049;
    logic [31:0] rd;
    logic        er;
    int          flips;
    int          n_errors = 0;
    int          checks = 0;
    int          cyc = 0;
    tcic_top uut (.CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pena),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(perr), .TIN_IN(tin), .MASTER_INT_IN(1'b0),
        .TOUT_OUT(tout), .INT_OUT(irq));
    tcic_pin_model u_pin (.clk_in(clk), .go_in(go), .tout_in(tout), .tin_out(tin),
        .flips_out(flips));
    always #50 clk = ~clk;
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] mode_word(input logic [2:0] md, input logic md0,
        input logic [2:0] sts, input logic [1:0] cis, input logic [1:0] cks);
        return (32'(cks) << CKS_LO) | (32'(sts) << STS_LO) | (32'(cis) << CIS_LO)
            | (32'(md) << MD_LO) | 32'(md0);
    endfunction
    // prescaler word 0x2130: ck0 /1, ck1 /8, ck2 /2, ck3 /4
    function automatic logic [31:0] period(input int c, input int k);
        int sh;
        sh = (k == 0) ? 0 : (k == 1) ? 1 : (k == 2) ? 3 : 2;
        return 32'((c + 1) << sh);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pena <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = perr;
        check(32'(k < 20), 32'h1);
        psel <= 1'b0;
        pena <= 1'b0;
    endtask
    task automatic wait_int(input int lim, output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < lim);
    endtask
    task automatic test_done;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            test_done();
        end
    end
    initial
    begin
        int c;
        int t;
        int f0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, ADDR_RESET_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, ADDR_CLOCK_EN, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, ADDR_COMPARE, 32'h5);
        apb(1'b0, ADDR_COMPARE, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h030, 32'h0);
        check({31'h0, er}, 32'h1);
        $display("test registers done");
        apb(1'b1, ADDR_RESET_CTRL, 32'h0);
        apb(1'b1, ADDR_CLOCK_EN, 32'h1);
        apb(1'b1, ADDR_OUT_ENABLE, 32'h2);
        apb(1'b1, ADDR_PRESCALER, 32'h2130);
        for (int k = 0; k < 4; k++)
        begin
            lfsr = next_rand(lfsr);
            c = 2 + lfsr[2:0];
            apb(1'b1, ADDR_STATUS, 32'h2);
            apb(1'b1, ADDR_MODE, mode_word(MD_INTERVAL, k[0], TRG_SOFT, EDG_FALL, 2'(k)));
            apb(1'b1, ADDR_COMPARE, 32'(c));
            f0 = flips;
            apb(1'b1, ADDR_START, 32'h2);
            wait_int(2000, t);
            if (k[0])
            begin
                check(32'(t <= 3), 32'h1);
                wait_int(2000, t);
            end
            wait_int(2000, t);
            check(32'(t), period(c, k));
            wait_int(2000, t);
            check(32'(t), period(c, k));
            repeat (3) @(posedge clk);
            check(32'(flips - f0), 32'(3 + k[0]));
        end
        $display("test interval done");
        apb(1'b1, ADDR_CLOCK_EN, 32'h0);
        repeat (3) @(posedge clk);
        wait_int(200, t);
        check(32'(t), 32'd200);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        apb(1'b1, ADDR_CLOCK_EN, 32'h1);
        apb(1'b1, ADDR_STATUS, 32'h2);
        apb(1'b1, ADDR_OUT_ENABLE, 32'h0);
        apb(1'b1, ADDR_OUT_VALUE, 32'h2);
        repeat (2) @(posedge clk);
        check(32'(tout), 32'h1);
        apb(1'b1, ADDR_OUT_POL, 32'h2);
        repeat (2) @(posedge clk);
        check(32'(tout), 32'h0);
        apb(1'b1, ADDR_OUT_POL, 32'h0);
        repeat (2) @(posedge clk);
        check(32'(tout), 32'h1);
        apb(1'b1, ADDR_OUT_ENABLE, 32'h2);
        apb(1'b1, ADDR_OUT_VALUE, 32'h0);
        apb(1'b0, ADDR_OUT_VALUE, 32'h0);
        check(rd, 32'h2);
        $display("test output done");
        apb(1'b1, ADDR_MODE, mode_word(MD_CAPTURE, 1'b0, TRG_EDGE, EDG_RISE, 2'h0));
        apb(1'b1, ADDR_START, 32'h2);
        repeat (20) @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wait_int(10, t);
        check(32'(t < 10), 32'h1);
        apb(1'b0, ADDR_CAPTURE, 32'h0);
        check(32'(rd >= 32'd10 && rd <= 32'd40), 32'h1);
        $display("test capture done");
        apb(1'b1, ADDR_STATUS, 32'h2);
        apb(1'b1, ADDR_MODE, mode_word(MD_EVENT, 1'b0, TRG_SOFT, EDG_RISE, 2'h0));
        apb(1'b1, ADDR_COMPARE, 32'h1);
        apb(1'b1, ADDR_START, 32'h2);
        for (int p = 0; p < 2; p++)
        begin
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            wait_int(8, t);
            check(32'(t < 8), 32'(p));
        end
        $display("test event done");
        test_done();
    end
endmodule
